// ---- common/cir_pkg.sv ----
// package: constants, frame layouts and crc helpers for the card register set
package cir_pkg;

    localparam int CMD_FRAME_W = 48;
    localparam int R2_FRAME_W = 136;
    localparam int REG_W = 128;
    localparam int CRC_W = 7;
    // leading frame bits protected by the response/command crc
    localparam int CRC_SPAN = 40;
    localparam int RESP_GAP_CLKS = 2;

    localparam logic [6:0] CRC_POLY = 7'h09;
    localparam logic [5:0] CMD_SEND_OP_COND = 6'h01;
    localparam logic [5:0] CMD_ALL_SEND_IDENT = 6'h02;
    localparam logic [5:0] CMD_SEND_SPECIFIC = 6'h09;
    localparam logic [5:0] CMD_SEND_IDENT = 6'h0A;
    localparam logic [5:0] CMD_PROGRAM_SPECIFIC = 6'h1B;
    localparam logic [5:0] RESP_FILL_INDEX = 6'h3F;
    localparam logic [6:0] R3_FILL_CRC = 7'h7F;

    localparam int COND_BUSY_BIT = 31;
    localparam int COND_LOW_VOLT_BIT = 7;
    localparam logic [31:0] COND_HV_WINDOW = 32'h00FF_8000;
    localparam int STATUS_OVERWRITE_BIT = 16;

    localparam logic [127:0] SPEC_OTP_MASK = {112'h0, 16'hEC00};
    localparam logic [127:0] SPEC_ERASE_MASK = {112'h0, 16'h13FE};
    localparam logic [127:0] SPEC_FIXED_MASK = {112'h0, 16'h0001};
    localparam logic [127:0] SPEC_RO_MASK = ~(SPEC_OTP_MASK | SPEC_ERASE_MASK | SPEC_FIXED_MASK);

    typedef struct packed {
        logic start_bit;
        logic dir_bit;
        logic [5:0] index;
        logic [31:0] argument;
        logic [6:0] crc;
        logic stop_bit;
    } cir_cmd_frame_type;

    typedef struct packed {
        logic [7:0] maker_code;
        logic [15:0] oem_application_code;
        logic [47:0] product_name_field;
        logic [7:0] product_revision_field;
        logic [31:0] serial_number_field;
        logic [7:0] manufacture_date_field;
        logic [6:0] crc;
        logic fixed_one;
    } cir_ident_type;

    function automatic logic [6:0] crc7_step(input logic [6:0] crc, input logic din);
        logic fb;
        fb = crc[6] ^ din;
        crc7_step = {crc[5:0], 1'b0} ^ (fb ? CRC_POLY : 7'h00);
    endfunction

    function automatic logic [6:0] crc7_span(input logic [119:0] data);
        logic [6:0] c;
        c = 7'h00;
        for (int i = 119; i >= 0; i--)
        begin
            c = crc7_step(c, data[i]);
        end
        crc7_span = c;
    endfunction

    // layout v1.2, spec v4, 1.5 ms access, 20 MHz, 512 byte blocks, size fields left at zero
    localparam logic [119:0] SPEC_BASE = {2'b10, 4'h4, 2'b00, 8'h26, 8'h01, 8'h2A, 12'h0F5,
        4'h9, 4'h0, 2'b00, 12'h000, 3'h6, 3'h0, 3'h6, 3'h0, 3'h0, 5'h00, 5'h00, 5'h00,
        1'b1, 2'b00, 3'h0, 4'h9, 1'b0, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 2'b00, 2'b00};
    localparam logic [127:0] SPEC_DEFAULT = {SPEC_BASE, crc7_span(SPEC_BASE), 1'b1};

endpackage

// ---- hdl/cir_sync.sv ----
// two-stage synchroniser for pins coming from the host side
`timescale 1ns/1ps
`default_nettype none
module cir_sync
#(
    parameter int WIDTH = 3
)(
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta;

    if (WIDTH < 1)
    begin : g_chk
        $error("cir_sync needs at least one bit");
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            meta <= '0;
            q_o <= '0;
        end
        else
        begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule
`default_nettype wire

// ---- hdl/cir_crc7.sv ----
// serial crc7 generator, one bit per shift strobe, msb first
`timescale 1ns/1ps
`default_nettype none
module cir_crc7
    import cir_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic clear_i,
    input wire logic shift_i,
    input wire logic bit_i,
    output logic [CRC_W-1:0] crc_o
);
    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i || clear_i)
        begin
            crc_o <= '0;
        end
        else if (shift_i)
        begin
            crc_o <= crc7_step(crc_o, bit_i);
        end
    end
endmodule
`default_nettype wire

// ---- hdl/cir_card_regs.sv ----
// card register set: power-up conditions, identification and programmable card data
`timescale 1ns/1ps
`default_nettype none
module cir_card_regs
    import cir_pkg::*;
#(
    parameter int POWERUP_CYCLES = 1000,
    parameter bit DUAL_VOLTAGE = 1'b0,
    parameter logic [7:0] MAKER_CODE = 8'h5A, // arbitrary value
    parameter logic [15:0] OEM_CODE = 16'h0001,
    parameter logic [47:0] PRODUCT_NAME = 48'h4341_5244_3031,
    parameter logic [7:0] PRODUCT_REV = 8'h10,
    parameter logic [31:0] SERIAL_NUMBER = 32'h0000_0001,
    parameter logic [7:0] MANUFACTURE_DATE = 8'h13
)(
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic card_clk_i,
    input wire logic cmd_i,
    input wire logic dat_i,
    output logic cmd_o,
    output logic cmd_oe_o,
    output logic card_ready_o,
    output logic program_error_o
);
    localparam int PWR_W = $clog2(POWERUP_CYCLES + 1);

    if (POWERUP_CYCLES < 1 || PRODUCT_REV[7:4] > 4'h9 || PRODUCT_REV[3:0] > 4'h9
        || MANUFACTURE_DATE[7:4] == 4'h0 || MANUFACTURE_DATE[7:4] > 4'hC)
    begin : g_chk
        $error("cir_card_regs: bad power-up count, revision or date");
    end

    typedef enum {ST_IDLE, ST_RX_CMD, ST_DECODE, ST_GAP, ST_TX,
        ST_DATA_WAIT, ST_DATA_RX, ST_APPLY} cir_state_type;

    cir_state_type state;
    logic [2:0] pins_s;
    logic link_clk_q;
    logic rise;
    logic fall;
    logic cmd_s;
    logic dat_s;
    logic [PWR_W-1:0] pwr_cnt;
    logic [31:0] cond_word;
    cir_ident_type ident_fields;
    logic [127:0] ident_word;
    logic [127:0] spec_data;
    logic [127:0] otp_used;
    logic [47:0] rx_sh;
    logic [5:0] rx_cnt;
    logic [1:0] gap_cnt;
    logic to_data;
    logic [127:0] dat_sh;
    logic [7:0] dat_cnt;
    logic [135:0] tx_sh;
    logic [7:0] tx_idx;
    logic [7:0] tx_len;
    logic tx_crc_mode;
    logic tx_od;
    logic tx_bit;
    logic tx_done;
    logic [7:0] crc_pos;
    logic [CRC_W-1:0] rx_crc;
    logic [CRC_W-1:0] tx_crc;
    cir_cmd_frame_type frame;
    logic frame_ok;
    logic resp_valid;
    logic is_program;
    logic [31:0] status_word;
    logic [135:0] next_tx_sh;
    logic [7:0] next_tx_len;
    logic next_crc_mode;
    logic next_od;
    logic ro_hit;
    logic otp_hit;
    logic prog_reject;
    logic load_cond;
    logic load_ident;

    // host clock, command and data pins all come from outside our clock
    cir_sync #(.WIDTH(3)) u_sync (
        .ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .d_i({card_clk_i, cmd_i, dat_i}),
        .q_o(pins_s)
    );

    assign cmd_s = pins_s[1];
    assign dat_s = pins_s[0];
    // host samples on its rising edge, so we sample there and drive on falling
    assign rise = pins_s[2] & ~link_clk_q;
    assign fall = ~pins_s[2] & link_clk_q;

    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            link_clk_q <= 1'b0;
        end
        else
        begin
            link_clk_q <= pins_s[2];
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            pwr_cnt <= '0;
            card_ready_o <= 1'b0;
        end
        else if (!card_ready_o)
        begin
            if (pwr_cnt == PWR_W'(POWERUP_CYCLES - 1))
            begin
                card_ready_o <= 1'b1;
            end
            else
            begin
                pwr_cnt <= pwr_cnt + 1'b1;
            end
        end
    end

    always_comb
    begin
        cond_word = COND_HV_WINDOW;
        cond_word[COND_LOW_VOLT_BIT] = DUAL_VOLTAGE;
        cond_word[COND_BUSY_BIT] = card_ready_o;
    end

    // identity values are parameters so each card build carries its own
    always_comb
    begin
        ident_fields.maker_code = MAKER_CODE;
        ident_fields.oem_application_code = OEM_CODE;
        ident_fields.product_name_field = PRODUCT_NAME;
        ident_fields.product_revision_field = PRODUCT_REV;
        ident_fields.serial_number_field = SERIAL_NUMBER;
        ident_fields.manufacture_date_field = MANUFACTURE_DATE;
        ident_fields.crc = crc7_span(ident_word[127:8]);
        ident_fields.fixed_one = 1'b1;
    end

    assign ident_word[127:8] = {MAKER_CODE, OEM_CODE, PRODUCT_NAME, PRODUCT_REV,
        SERIAL_NUMBER, MANUFACTURE_DATE};
    assign ident_word[7:0] = {ident_fields.crc, ident_fields.fixed_one};

    cir_crc7 u_rx_crc (
        .ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .clear_i((state == ST_IDLE || state == ST_DATA_WAIT) && !(rise && !cmd_s)),
        .shift_i(rise && (((state == ST_IDLE || state == ST_DATA_WAIT) && !cmd_s)
            || (state == ST_RX_CMD && rx_cnt < 6'(CRC_SPAN)))),
        .bit_i(cmd_s),
        .crc_o(rx_crc)
    );

    always_comb
    begin
        status_word = '0;
        status_word[STATUS_OVERWRITE_BIT] = program_error_o;
    end

    // only these command indices reach a register; everything else is silent
    always_comb
    begin
        frame = cir_cmd_frame_type'(rx_sh);
        frame_ok = !frame.start_bit && frame.dir_bit && frame.stop_bit && frame.crc == rx_crc;
        resp_valid = 1'b0;
        is_program = 1'b0;
        next_tx_sh = '0;
        next_tx_len = 8'(CMD_FRAME_W);
        next_crc_mode = 1'b0;
        next_od = 1'b0;
        if (frame_ok)
        begin
            case (frame.index)
                CMD_SEND_OP_COND:
                begin
                    resp_valid = 1'b1;
                    next_od = 1'b1;
                    next_tx_sh = {2'b00, RESP_FILL_INDEX, cond_word, R3_FILL_CRC, 1'b1, 88'h0};
                end
                CMD_ALL_SEND_IDENT, CMD_SEND_IDENT:
                begin
                    resp_valid = card_ready_o;
                    next_tx_len = 8'(R2_FRAME_W);
                    next_tx_sh = {2'b00, RESP_FILL_INDEX, ident_word[127:1], 1'b1};
                end
                CMD_SEND_SPECIFIC:
                begin
                    resp_valid = card_ready_o;
                    next_tx_len = 8'(R2_FRAME_W);
                    next_tx_sh = {2'b00, RESP_FILL_INDEX, spec_data[127:1], 1'b1};
                end
                CMD_PROGRAM_SPECIFIC:
                begin
                    resp_valid = card_ready_o;
                    is_program = card_ready_o;
                    next_crc_mode = 1'b1;
                    next_tx_sh = {2'b00, frame.index, status_word, 7'h00, 1'b1, 88'h0};
                end
                default:
                begin
                    resp_valid = 1'b0;
                end
            endcase
        end
    end

    assign load_cond = state == ST_DECODE && resp_valid && frame.index == CMD_SEND_OP_COND;
    assign load_ident = state == ST_DECODE && resp_valid
        && (frame.index == CMD_ALL_SEND_IDENT || frame.index == CMD_SEND_IDENT);

    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            state <= ST_IDLE;
            rx_sh <= '0;
            rx_cnt <= '0;
            gap_cnt <= '0;
            to_data <= 1'b0;
            dat_sh <= '0;
            dat_cnt <= '0;
        end
        else
        begin
            case (state)
                ST_IDLE, ST_DATA_WAIT:
                begin
                    if (rise && !cmd_s)
                    begin
                        // a new command also abandons a pending data block
                        rx_sh <= {rx_sh[46:0], cmd_s};
                        rx_cnt <= 6'd1;
                        state <= ST_RX_CMD;
                    end
                    else if (state == ST_DATA_WAIT && rise && !dat_s)
                    begin
                        dat_cnt <= '0;
                        state <= ST_DATA_RX;
                    end
                end
                ST_RX_CMD:
                begin
                    if (rise)
                    begin
                        rx_sh <= {rx_sh[46:0], cmd_s};
                        rx_cnt <= rx_cnt + 1'b1;
                        if (rx_cnt == 6'(CMD_FRAME_W - 1))
                        begin
                            state <= ST_DECODE;
                        end
                    end
                end
                ST_DECODE:
                begin
                    gap_cnt <= '0;
                    to_data <= is_program;
                    state <= resp_valid ? ST_GAP : ST_IDLE;
                end
                ST_GAP:
                begin
                    if (rise)
                    begin
                        gap_cnt <= gap_cnt + 1'b1;
                        if (gap_cnt == 2'(RESP_GAP_CLKS - 1))
                        begin
                            state <= ST_TX;
                        end
                    end
                end
                ST_TX:
                begin
                    if (tx_done)
                    begin
                        state <= to_data ? ST_DATA_WAIT : ST_IDLE;
                    end
                end
                ST_DATA_RX:
                begin
                    if (rise)
                    begin
                        if (dat_cnt == 8'(REG_W))
                        begin
                            state <= dat_s ? ST_APPLY : ST_IDLE;
                        end
                        else
                        begin
                            dat_sh <= {dat_sh[126:0], dat_s};
                            dat_cnt <= dat_cnt + 1'b1;
                        end
                    end
                end
                ST_APPLY:
                begin
                    state <= ST_IDLE;
                end
                default:
                begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    cir_crc7 u_tx_crc (
        .ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .clear_i(state == ST_DECODE),
        .shift_i(state == ST_TX && fall && tx_idx < 8'(CRC_SPAN)),
        .bit_i(tx_sh[135]),
        .crc_o(tx_crc)
    );

    assign crc_pos = tx_idx - 8'(CRC_SPAN);
    assign tx_bit = (tx_crc_mode && tx_idx >= 8'(CRC_SPAN) && crc_pos < 8'(CRC_W))
        ? tx_crc[3'(CRC_W - 1) - crc_pos[2:0]] : tx_sh[135];
    assign tx_done = state == ST_TX && fall && tx_idx == tx_len;

    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            tx_sh <= '0;
            tx_idx <= '0;
            tx_len <= '0;
            tx_crc_mode <= 1'b0;
            tx_od <= 1'b0;
            cmd_o <= 1'b1;
            cmd_oe_o <= 1'b0;
        end
        else if (state == ST_DECODE && resp_valid)
        begin
            tx_sh <= next_tx_sh;
            tx_len <= next_tx_len;
            tx_crc_mode <= next_crc_mode;
            tx_od <= next_od;
            tx_idx <= '0;
        end
        else if (state == ST_TX && fall)
        begin
            if (tx_idx == tx_len)
            begin
                cmd_o <= 1'b1;
                cmd_oe_o <= 1'b0;
            end
            else
            begin
                // open drain only pulls low, so any busy card wins the line
                cmd_o <= tx_od ? 1'b0 : tx_bit;
                cmd_oe_o <= tx_od ? !tx_bit : 1'b1;
                tx_sh <= {tx_sh[134:0], 1'b0};
                tx_idx <= tx_idx + 1'b1;
            end
        end
    end

    // the fixed bit is forced rather than checked, so a host may send it either way
    assign ro_hit = |((dat_sh ^ spec_data) & SPEC_RO_MASK);
    assign otp_hit = |((dat_sh ^ spec_data) & SPEC_OTP_MASK & otp_used);
    assign prog_reject = state == ST_APPLY && (ro_hit || otp_hit);

    // card data is volatile here: reset restores the factory image
    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            spec_data <= SPEC_DEFAULT;
            otp_used <= '0;
            program_error_o <= 1'b0;
        end
        else
        begin
            if (state == ST_DECODE && is_program)
            begin
                program_error_o <= 1'b0;
            end
            if (prog_reject)
            begin
                program_error_o <= 1'b1;
            end
            else if (state == ST_APPLY)
            begin
                spec_data <= dat_sh | SPEC_FIXED_MASK;
                otp_used <= otp_used | ((dat_sh ^ spec_data) & SPEC_OTP_MASK);
            end
        end
    end

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rstn_i);

    sequence s_prog_reject;
        state == ST_APPLY ##0 (ro_hit || otp_hit);
    endsequence

    sequence s_card_change;
        !$stable(spec_data);
    endsequence

    a_ready_time: assert property ($rose(card_ready_o) |-> $past(pwr_cnt) == PWR_W'(POWERUP_CYCLES - 1))
        else $error("ready rose before power-up count ended");
    a_cond_busy_bit: assert property (load_cond |=> tx_sh[127] == $past(card_ready_o))
        else $error("busy bit in response does not follow power-up");
    a_cond_window: assert property (load_cond |=> tx_sh[119:111] == 9'h1FF && tx_sh[110:104] == 7'h00
        && tx_sh[103] == DUAL_VOLTAGE && tx_sh[102:96] == 7'h00 && tx_sh[126:120] == 7'h00)
        else $error("voltage window wrong");
    a_wired_and: assert property (tx_od && cmd_oe_o |-> !cmd_o)
        else $error("operating conditions driven high");
    a_ident_layout: assert property (load_ident |=> tx_sh[127:120] == MAKER_CODE && tx_sh[0]
        && tx_sh[119:104] == OEM_CODE && tx_sh[47:16] == SERIAL_NUMBER)
        else $error("identification layout wrong");
    a_ident_crc: assert property (load_ident |=> tx_sh[7:1] == crc7_span(tx_sh[127:8]))
        else $error("identification crc wrong");
    a_spec_readonly: assert property (state == ST_APPLY
        |=> ((spec_data ^ $past(spec_data)) & SPEC_RO_MASK) == '0)
        else $error("read-only card data changed");
    a_spec_source: assert property (s_card_change |-> $past(state == ST_APPLY) && !$past(prog_reject))
        else $error("card data changed outside program");
    a_reject_keep: assert property (s_prog_reject |=> $stable(spec_data) && program_error_o)
        else $error("rejected program altered card data");
    a_spec_fixed: assert property (spec_data[0] && spec_data[127:122] == SPEC_DEFAULT[127:122])
        else $error("card data fixed fields lost");
    a_tx_msb: assert property (state == ST_TX && fall && tx_idx < 8'(CRC_SPAN) && !tx_od
        |=> cmd_o == $past(tx_sh[135]) && cmd_oe_o)
        else $error("response not sent msb first");

endmodule
`default_nettype wire

// ---- verif/cir_host_model.sv ----
// host-side model: bus clock, command frames and program data blocks
`timescale 1ns/1ps
`default_nettype none
module cir_host_model
(
    input wire logic ref_clk_i,
    input wire logic cmd_o,
    input wire logic cmd_oe_o,
    output logic card_clk_o,
    output logic cmd_line_o,
    output logic dat_o
);
    logic h_oe;
    logic h_v;
    logic od_phase;

    // pull-up wins unless some party drives low
    assign cmd_line_o = ~((h_oe & ~h_v) | (cmd_oe_o & ~cmd_o));

    initial
    begin
        card_clk_o = 1'b0;
        h_oe = 1'b0;
        h_v = 1'b1;
        dat_o = 1'b1;
        od_phase = 1'b0;
    end

    function automatic logic [6:0] crc7(input logic [119:0] d, input int n);
        logic [6:0] c;
        logic fb;
        c = 7'h00;
        for (int i = 119; i > 119 - n; i--)
        begin
            fb = c[6] ^ d[i];
            c = {c[5:0], 1'b0} ^ {3'b000, fb, 2'b00, fb};
        end
        return c;
    endfunction

    // clock stands low between frames; lines change only while it is low
    task automatic tick(output logic s);
        card_clk_o = 1'b1;
        s = cmd_line_o;
        #80;
        card_clk_o = 1'b0;
        #80;
    endtask

    task automatic xfer(input logic [5:0] idx, input logic [31:0] arg, input int rlen,
        output logic [135:0] r, output logic got);
        logic [47:0] f;
        logic s;
        int k;
        @(posedge ref_clk_i);
        #1;
        f = {2'b01, idx, arg, 8'h01};
        f[7:1] = crc7({f[47:8], 80'h0}, 40);
        od_phase = (idx == 6'h01);
        h_oe = 1'b1;
        for (int i = 47; i >= 0; i--)
        begin
            h_v = f[i];
            tick(s);
        end
        h_oe = 1'b0;
        h_v = 1'b1;
        r = '0;
        got = 1'b0;
        k = 0;
        while (!got && k < 8)
        begin
            tick(s);
            got = (s === 1'b0);
            k++;
        end
        for (int i = 1; got && i < rlen; i++)
        begin
            tick(s);
            r = {r[134:0], s};
        end
        tick(s);
        tick(s);
        od_phase = 1'b0;
    endtask

    // one block per program command, start bit low, end bit as given
    task automatic send_block(input logic [127:0] d, input logic e);
        logic s;
        @(posedge ref_clk_i);
        #1;
        dat_o = 1'b0;
        tick(s);
        for (int i = 127; i >= 0; i--)
        begin
            dat_o = d[i];
            tick(s);
        end
        dat_o = e;
        tick(s);
        dat_o = 1'b1;
        tick(s);
        tick(s);
    endtask
endmodule
`default_nettype wire

// ---- verif/tb_top.sv ----
// self-checking bench: power-up, identification reads and card data programming
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import cir_pkg::*;
;
    localparam int PU = 4000;
    localparam logic [7:0] MK = 8'hC3; // arbitrary value
    localparam logic [119:0] IDENT_TOP = {MK, 16'h2B4D, 48'h5445_5354_4142, 8'h21,
        32'hDEAD_0007, 8'h4A};
    logic ref_clk;
    logic rstn;
    logic card_clk;
    logic cmd_line;
    logic dat;
    logic cmd_o;
    logic cmd_oe;
    logic ready;
    logic perr;
    logic got;
    logic [135:0] r;
    logic [127:0] ident;
    logic [127:0] spec;
    int n_fail;
    int num_checks;
    int cyc;
    int rdy_at;

    cir_card_regs #(
        .POWERUP_CYCLES(PU),
        .MAKER_CODE(MK),
        .OEM_CODE(16'h2B4D),
        .PRODUCT_NAME(48'h5445_5354_4142),
        .PRODUCT_REV(8'h21),
        .SERIAL_NUMBER(32'hDEAD_0007),
        .MANUFACTURE_DATE(8'h4A)
    ) u_cir_card_regs (
        .ref_clk_i(ref_clk),
        .rstn_i(rstn),
        .card_clk_i(card_clk),
        .cmd_i(cmd_line),
        .dat_i(dat),
        .cmd_o(cmd_o),
        .cmd_oe_o(cmd_oe),
        .card_ready_o(ready),
        .program_error_o(perr)
    );

    cir_host_model u_cir_host_model (
        .ref_clk_i(ref_clk),
        .cmd_o(cmd_o),
        .cmd_oe_o(cmd_oe),
        .card_clk_o(card_clk),
        .cmd_line_o(cmd_line),
        .dat_o(dat)
    );

    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic chk(input string what, input logic [135:0] exp, input logic [135:0] v);
        num_checks++;
        if (v !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, v);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic cmd(input logic [5:0] idx, input int rlen);
        u_cir_host_model.xfer(idx, 32'h0, rlen, r, got);
    endtask

    // program, check the reply and the error flag, then read the image back
    task automatic prog(input logic [127:0] d, input logic e, input logic was_err,
        input logic ok);
        cmd(CMD_PROGRAM_SPECIFIC, 48);
        chk("program reply", {8'h1B, 15'h0, was_err, 16'h0}, r[47:8]);
        chk("reply crc", {u_cir_host_model.crc7({r[47:8], 80'h0}, 40), 1'b1}, r[7:0]);
        chk("error cleared", 0, perr);
        u_cir_host_model.send_block(d, e);
        if (e)
            chk("program error", !ok, perr);
        if (ok && e)
            spec = {d[127:1], 1'b1};
        cmd(CMD_SEND_SPECIFIC, 136);
        chk("data after program", {8'h3F, spec}, r);
    endtask

    always @(posedge ref_clk)
    begin
        cyc <= rstn ? cyc + 1 : 0;
        if (ready === 1'b1 && rdy_at < 0)
            rdy_at <= cyc;
        if (u_cir_host_model.od_phase && cmd_oe === 1'b1)
            chk("open drain drive", 0, cmd_o);
        if (cyc > 90000)
        begin
            n_fail++;
            end_of_test();
        end
    end

    initial
    begin
        rstn = 1'b0;
        n_fail = 0;
        num_checks = 0;
        rdy_at = -1;
        ident = {IDENT_TOP, u_cir_host_model.crc7(IDENT_TOP, 120), 1'b1};
        spec = SPEC_DEFAULT;
        repeat (3) @(posedge ref_clk);
        #1;
        rstn = 1'b1;
        @(posedge ref_clk);
        #1;
        chk("idle outputs", 4'b1000, {cmd_o, cmd_oe, ready, perr});
        $display("test reset done");
        cmd(CMD_ALL_SEND_IDENT, 136);
        chk("ident while busy", 0, got);
        cmd(CMD_SEND_OP_COND, 48);
        chk("busy conditions", {8'h3F, 32'h00FF_8000, 8'hFF}, r);
        while (ready !== 1'b1 && cyc < 3 * PU)
            @(posedge ref_clk);
        #1;
        chk("power-up time", 1, rdy_at >= PU && rdy_at <= PU + 2);
        cmd(CMD_SEND_OP_COND, 48);
        chk("ready conditions", {8'h3F, 32'h80FF_8000, 8'hFF}, r);
        $display("test conditions done");
        cmd(6'h05, 136);
        chk("unknown command", 0, got);
        cmd(CMD_ALL_SEND_IDENT, 136);
        chk("ident all", {8'h3F, ident}, r);
        cmd(CMD_SEND_IDENT, 136);
        chk("ident addressed", {8'h3F, ident}, r);
        $display("test ident done");
        cmd(CMD_SEND_SPECIFIC, 136);
        chk("data layout", {2'b10, 4'h4}, r[127:122]);
        chk("data crc", {u_cir_host_model.crc7(SPEC_DEFAULT[127:8], 120), 1'b1}, r[7:0]);
        chk("data image", {8'h3F, spec}, r);
        prog(spec ^ 128'h9000, 1'b1, 1'b0, 1'b1);
        prog(spec ^ (128'h1 << 100), 1'b1, 1'b0, 1'b0);
        prog(spec ^ 128'h8000, 1'b1, 1'b1, 1'b0);
        prog(spec ^ 128'h1301, 1'b1, 1'b1, 1'b1);
        prog(spec ^ 128'h0200, 1'b0, 1'b0, 1'b0);
        $display("test program done");
        end_of_test();
    end
endmodule
`default_nettype wire
